//--- per_event_page_regs.sv
/*
  management register block: extended event status and mask,
  timing-role swap control and status, page select, aux clock
  output control and the aux clock generator.
  assumes a single 200 MHz clock; all event and link inputs come
  from logic on that clock; the register port reads one cycle late.
*/
// Added by the designer: strobed register access.
`include "per_regs.svh"

module per_event_page_regs
  import per_pkg::*;
(
  // clock and resets
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        sticky_rst,
  input  wire logic        soft_rst,
  // register port
  input  wire logic [4:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  // event pulses from the datapath
  input  wire logic        rx_fifo_err,
  input  wire logic        tx_fifo_err,
  input  wire logic        eee_link_fail,
  input  wire logic        eee_rx_quiet,
  input  wire logic        eee_wait_quiet,
  input  wire logic        eee_wake_err,
  // link and negotiation state
  input  wire logic        link_up,
  input  wire logic        aneg_master,
  input  wire logic        link_partner_swap_adv,
  input  wire logic        swap_ack,
  // timing role swap controls
  output logic             master_training_enable,
  output logic             swap_advertise,
  output logic             swap_enabled,
  output logic             swap_req,
  // interrupt
  output logic             irq,
  // aux clock output pin
  output logic             aux_clock_output_pin,
  output logic             aux_clock_output_pin_oe
);

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  logic [15:0] page;

  function automatic logic hit(input logic [15:0] pg, input logic [4:0] a,
                               input logic [15:0] want_pg, input logic [4:0] want_a);
    hit = (pg == want_pg) && (a == want_a);
  endfunction : hit

  logic wr_page, wr_mask, wr_stat, wr_role, wr_clk, rd_stat;

  always_comb begin
    wr_page = reg_wr && (reg_addr == `PER_ADDR_PAGE);
    wr_mask = reg_wr && hit(page, reg_addr, `PER_PAGE_EXT2, `PER_ADDR_MASK);
    wr_stat = reg_wr && hit(page, reg_addr, `PER_PAGE_EXT2, `PER_ADDR_STAT);
    wr_role = reg_wr && hit(page, reg_addr, `PER_PAGE_EXT2, `PER_ADDR_ROLE);
    wr_clk  = reg_wr && hit(page, reg_addr, `PER_PAGE_GP, `PER_ADDR_AUX_CLK);
    rd_stat = reg_rd && hit(page, reg_addr, `PER_PAGE_EXT2, `PER_ADDR_STAT);
  end

  // ------------------------------------------------------------
  // reset qualifiers
  // ------------------------------------------------------------
  // the next values already see the lighter resets, so that the
  // registered outputs drop in the same edge as the state they mirror
  logic clr_volatile;
  logic clr_sticky;

  always_comb begin
    clr_volatile = soft_rst || sticky_rst;
    clr_sticky   = sticky_rst;
  end

  // ------------------------------------------------------------
  // page select: power-on only, readable back
  // ------------------------------------------------------------
  logic [15:0] next_page;

  always_comb begin
    next_page = page;
    if (wr_page) begin
      next_page = reg_wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      page <= `PER_PAGE_MAIN;
    end else begin
      page <= next_page;
    end
  end

  // ------------------------------------------------------------
  // event status and mask
  // ------------------------------------------------------------
  logic [15:0] evt_stat;
  logic [15:0] evt_mask;
  logic [15:0] next_evt_stat;
  logic [15:0] next_evt_mask;
  logic [15:0] evt_in;
  logic        swap_done;

  always_comb begin
    evt_in = `PER_RST_WORD;
    evt_in[`PER_EVT_RX_FIFO]   = rx_fifo_err;
    evt_in[`PER_EVT_TX_FIFO]   = tx_fifo_err;
    evt_in[`PER_EVT_SWAP_DONE] = swap_done;
    evt_in[`PER_EVT_EEE_LFAIL] = eee_link_fail;
    evt_in[`PER_EVT_EEE_QUIET] = eee_rx_quiet;
    evt_in[`PER_EVT_EEE_SLEEP] = eee_wait_quiet;
    evt_in[`PER_EVT_EEE_WAKE]  = eee_wake_err;
    next_evt_stat = evt_stat;
    // a read clears what it reported; write-one also clears
    if (rd_stat) begin
      next_evt_stat = `PER_RST_WORD;
    end
    if (wr_stat) begin
      next_evt_stat = next_evt_stat & ~reg_wdata;
    end
    // a new event wins over a clear in the same cycle
    next_evt_stat = (next_evt_stat | evt_in) & `PER_EVT_BITS;
    next_evt_mask = evt_mask;
    if (wr_mask) begin
      next_evt_mask = reg_wdata & `PER_EVT_BITS;
    end
    // the lighter resets win over events and writes alike
    if (clr_volatile) begin
      next_evt_stat = `PER_RST_WORD;
    end
    if (clr_sticky) begin
      next_evt_mask = `PER_RST_WORD;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst || soft_rst || sticky_rst) begin
      evt_stat <= `PER_RST_WORD;
    end else begin
      evt_stat <= next_evt_stat;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst || sticky_rst) begin
      evt_mask <= `PER_RST_WORD;
    end else begin
      evt_mask <= next_evt_mask;
    end
  end

  // ------------------------------------------------------------
  // timing-role swap control bits (sticky)
  // ------------------------------------------------------------
  logic [15:0] role_ctl;
  logic [15:0] next_role_ctl;

  always_comb begin
    next_role_ctl = role_ctl;
    if (wr_role) begin
      next_role_ctl = reg_wdata & `PER_ROLE_STICKY;
    end
    // a sticky reset also clears the outputs that mirror these bits
    if (clr_sticky) begin
      next_role_ctl = `PER_RST_WORD;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst || sticky_rst) begin
      role_ctl <= `PER_RST_WORD;
    end else begin
      role_ctl <= next_role_ctl;
    end
  end

  // ------------------------------------------------------------
  // timing-role state machine
  // ------------------------------------------------------------
  per_role_t role;
  per_role_t next_role;
  logic      link_q;
  logic      partner_adv;
  logic      next_partner_adv;
  logic      swap_ok;
  logic      start_ok;

  always_comb begin
    swap_ok   = role_ctl[`PER_ROLE_FORCE] ||
                (role_ctl[`PER_ROLE_ADV] && partner_adv);
    // a start during a reset would request a role that the reset discards
    start_ok  = wr_role && reg_wdata[`PER_ROLE_START] && swap_ok && link_q && !clr_volatile &&
                (role == ROLE_SLAVE || role == ROLE_MASTER);
    next_role = role;
    swap_done = 1'b0;
    next_partner_adv = partner_adv;
    if (link_up && !link_q) begin
      next_role        = aneg_master ? ROLE_MASTER : ROLE_SLAVE;
      next_partner_adv = link_partner_swap_adv;
    end else if (!link_up) begin
      next_role        = ROLE_SLAVE;
      next_partner_adv = 1'b0;
    end else begin
      case (role)
        ROLE_SLAVE: begin
          if (start_ok) begin
            next_role = ROLE_S2M;
          end
        end
        ROLE_MASTER: begin
          if (start_ok) begin
            next_role = ROLE_M2S;
          end
        end
        ROLE_S2M: begin
          if (swap_ack) begin
            next_role = ROLE_MASTER;
            swap_done = 1'b1;
          end
        end
        ROLE_M2S: begin
          if (swap_ack) begin
            next_role = ROLE_SLAVE;
            swap_done = 1'b1;
          end
        end
        default: begin
          next_role = ROLE_SLAVE;
        end
      endcase
    end
    if (clr_volatile) begin
      next_partner_adv = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst || soft_rst || sticky_rst) begin
      role   <= ROLE_SLAVE;
      link_q <= 1'b0;
      partner_adv <= 1'b0;
    end else begin
      role   <= next_role;
      link_q <= link_up;
      partner_adv <= next_partner_adv;
    end
  end

  // ------------------------------------------------------------
  // aux clock control (super-sticky) and generator
  // ------------------------------------------------------------
  logic [15:0] clk_ctl;
  logic [15:0] next_clk_ctl;
  logic [15:0] phase;
  logic [15:0] next_phase;
  logic [15:0] inc;
  logic        clk_run;

  // the pin is the msb of a phase accumulator: 25 and 50 MHz are exact,
  // while 125 MHz lies above half the core clock and comes out as its
  // alias at the difference of the two; the reserved code holds it low
  always_comb begin
    next_clk_ctl = clk_ctl;
    if (wr_clk) begin
      next_clk_ctl = reg_wdata & `PER_CLK_BITS;
    end
    case (per_freq_t'(clk_ctl[`PER_CLK_SEL_HI:`PER_CLK_SEL_LO]))
      FREQ_25M:  inc = `PER_INC_25M;
      FREQ_50M:  inc = `PER_INC_50M;
      FREQ_125M: inc = `PER_INC_125M;
      default:   inc = `PER_RST_WORD;
    endcase
    clk_run    = clk_ctl[`PER_CLK_EN] && (inc != `PER_RST_WORD);
    next_phase = clk_run ? 16'(phase + inc) : `PER_RST_WORD;
  end

  // only power-on clears the general purpose space
  always_ff @(posedge core_clk) begin
    if (rst) begin
      clk_ctl <= `PER_RST_WORD;
    end else begin
      clk_ctl <= next_clk_ctl;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      phase <= `PER_RST_WORD;
    end else begin
      phase <= next_phase;
    end
  end

  // ------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------
  logic [15:0] next_rdata;

  always_comb begin
    // unmapped pages and addresses read zero
    next_rdata = `PER_RST_WORD;
    if (reg_rd) begin
      if (reg_addr == `PER_ADDR_PAGE) begin
        next_rdata = page;
      end else if (hit(page, reg_addr, `PER_PAGE_EXT2, `PER_ADDR_MASK)) begin
        next_rdata = evt_mask;
      end else if (hit(page, reg_addr, `PER_PAGE_EXT2, `PER_ADDR_STAT)) begin
        next_rdata = evt_stat;
      end else if (hit(page, reg_addr, `PER_PAGE_EXT2, `PER_ADDR_ROLE)) begin
        next_rdata = role_ctl;
        next_rdata[`PER_ROLE_PARTNER_ADV] = partner_adv;
        next_rdata[`PER_ROLE_ST_HI:`PER_ROLE_ST_LO] = role;
        next_rdata[`PER_ROLE_START] = (role == ROLE_S2M) || (role == ROLE_M2S);
      end else if (hit(page, reg_addr, `PER_PAGE_GP, `PER_ADDR_AUX_CLK)) begin
        next_rdata = clk_ctl;
      end
    end
  end

  // ------------------------------------------------------------
  // registered outputs
  // ------------------------------------------------------------
  // outputs other than aux_clock_output_pin_oe are taken from the next values so that each one changes
  // in the same edge as the register it reports; aux_clock_output_pin_oe follows clk_ctl one edge later
  always_ff @(posedge core_clk) begin
    if (rst) begin
      reg_rdata               <= `PER_RST_WORD;
      irq                     <= 1'b0;
      master_training_enable  <= 1'b0;
      swap_advertise          <= 1'b0;
      swap_enabled            <= 1'b0;
      swap_req                <= 1'b0;
      aux_clock_output_pin    <= 1'b0;
      aux_clock_output_pin_oe <= 1'b0;
    end else begin
      reg_rdata               <= next_rdata;
      irq                     <= |(next_evt_stat & next_evt_mask);
      master_training_enable  <= next_role_ctl[`PER_ROLE_STARTUP];
      swap_advertise          <= next_role_ctl[`PER_ROLE_ADV];
      swap_enabled            <= next_role_ctl[`PER_ROLE_FORCE] ||
                                 (next_role_ctl[`PER_ROLE_ADV] && next_partner_adv);
      swap_req                <= start_ok;
      aux_clock_output_pin    <= clk_run && next_phase[`PER_PHASE_MSB];
      aux_clock_output_pin_oe <= clk_ctl[`PER_CLK_EN];
    end
  end

endmodule : per_event_page_regs

//--- per_regs.svh
/*
  register offsets, page codes, field positions and reset values
  of the event, timing-role swap, page and aux clock registers.
  assumes a 5-bit register address and 16-bit register data.
*/
`ifndef PER_REGS_SVH
`define PER_REGS_SVH

// ------------------------------------------------------------
// register addresses inside the 32-register window
// ------------------------------------------------------------
`define PER_ADDR_AUX_CLK    5'h0d
`define PER_ADDR_MASK       5'h1c
`define PER_ADDR_STAT       5'h1d
`define PER_ADDR_ROLE       5'h1e
`define PER_ADDR_PAGE       5'h1f

// ------------------------------------------------------------
// page codes written to the page register
// ------------------------------------------------------------
`define PER_PAGE_MAIN       16'h0000
`define PER_PAGE_EXT2       16'h0002
`define PER_PAGE_GP         16'h0010

// ------------------------------------------------------------
// extended event status / mask layout
// ------------------------------------------------------------
`define PER_EVT_RX_FIFO     13
`define PER_EVT_TX_FIFO     12
`define PER_EVT_SWAP_DONE   4
`define PER_EVT_EEE_LFAIL   3
`define PER_EVT_EEE_QUIET   2
`define PER_EVT_EEE_SLEEP   1
`define PER_EVT_EEE_WAKE    0
`define PER_EVT_BITS        16'h301f

// ------------------------------------------------------------
// timing-role swap control layout
// ------------------------------------------------------------
`define PER_ROLE_STARTUP    15
`define PER_ROLE_ADV        14
`define PER_ROLE_PARTNER_ADV 13
`define PER_ROLE_FORCE      12
`define PER_ROLE_ST_HI      5
`define PER_ROLE_ST_LO      4
`define PER_ROLE_START      0
`define PER_ROLE_STICKY     16'hd000

// ------------------------------------------------------------
// aux clock output control layout
// ------------------------------------------------------------
`define PER_CLK_EN          15
`define PER_CLK_SEL_HI      14
`define PER_CLK_SEL_LO      13
`define PER_CLK_BITS        16'he000
`define PER_RST_WORD        16'h0000

// ------------------------------------------------------------
// phase increments for a 16-bit accumulator at 200 MHz
// ------------------------------------------------------------
`define PER_INC_25M         16'h2000
`define PER_INC_50M         16'h4000
`define PER_INC_125M        16'ha000
`define PER_PHASE_MSB       15

`endif

//--- per_pkg.sv
/*
  types shared by the event and page register block.
  assumes nothing beyond a SystemVerilog compiler.
*/
package per_pkg;

  // ------------------------------------------------------------
  // timing role as reported in the swap control register
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    ROLE_SLAVE     = 2'b00,
    ROLE_M2S       = 2'b01,
    ROLE_S2M       = 2'b10,
    ROLE_MASTER    = 2'b11
  } per_role_t;

  // ------------------------------------------------------------
  // aux clock frequency select codes
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    FREQ_25M       = 2'b00,
    FREQ_50M       = 2'b01,
    FREQ_125M      = 2'b10,
    FREQ_RSVD      = 2'b11
  } per_freq_t;

endpackage : per_pkg

//--- per_event_page_regs_checker.sv
/*
  concurrent checks on the ports of the event and page register block.
  assumes a bind onto per_event_page_regs and a single clock domain.
*/
module per_event_page_regs_checker (
  // clock and resets
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        sticky_rst,
  input wire logic        soft_rst,
  // register port
  input wire logic [4:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  // events
  input wire logic        rx_fifo_err,
  input wire logic        tx_fifo_err,
  input wire logic        eee_link_fail,
  input wire logic        eee_rx_quiet,
  input wire logic        eee_wait_quiet,
  input wire logic        eee_wake_err,
  input wire logic        swap_ack,
  // outputs
  input wire logic        master_training_enable,
  input wire logic        swap_advertise,
  input wire logic        swap_req,
  input wire logic        irq,
  input wire logic        aux_clock_output_pin,
  input wire logic        aux_clock_output_pin_oe
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  property p_rdata_idle;
    !$past(reg_rd) |-> reg_rdata == 16'h0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");
  property p_pin_off;
    !aux_clock_output_pin_oe |-> !aux_clock_output_pin;
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("aux clock toggles while disabled");
  property p_oe_rise;
    $rose(aux_clock_output_pin_oe) |-> $past(reg_wr) || $past(reg_wr, 2);
  endproperty
  a_oe_rise: assert property (p_oe_rise) else $error("aux clock enable without write");
  property p_req_pulse;
    swap_req |=> !swap_req;
  endproperty
  a_req_pulse: assert property (p_req_pulse) else $error("switchover request longer than one cycle");
  property p_req_cause;
    swap_req |-> $past(reg_wr && reg_addr == 5'h1e && reg_wdata[0]);
  endproperty
  a_req_cause: assert property (p_req_cause) else $error("switchover request without start write");
  property p_irq_rise;
    $rose(irq) |-> $past(reg_wr || swap_ack || rx_fifo_err || tx_fifo_err || eee_link_fail
                         || eee_rx_quiet || eee_wait_quiet || eee_wake_err);
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("interrupt without event");
  property p_irq_fall;
    $fell(irq) |-> $past(reg_rd || reg_wr || sticky_rst || soft_rst);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("interrupt dropped by itself");
  property p_ctl_stable;
    $changed({master_training_enable, swap_advertise}) |->
      $past(reg_wr) || $past(reg_wr, 2) || $past(sticky_rst) || $past(sticky_rst, 2);
  endproperty
  a_ctl_stable: assert property (p_ctl_stable) else $error("swap controls changed unprompted");
endmodule : per_event_page_regs_checker

bind per_event_page_regs per_event_page_regs_checker u_chk (
  .core_clk, .rst, .sticky_rst, .soft_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .rx_fifo_err, .tx_fifo_err, .eee_link_fail, .eee_rx_quiet, .eee_wait_quiet, .eee_wake_err,
  .swap_ack, .master_training_enable, .swap_advertise, .swap_req, .irq,
  .aux_clock_output_pin, .aux_clock_output_pin_oe
);

//--- per_event_page_regs_test.sv
/*
  self-checking bench for the event and page register block.
  assumes the checker is bound in.
*/
module per_event_page_regs_test;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {
    logic [5:0]  ev;
    logic [15:0] st;
  } per_row_t;
  per_row_t rows [6] = '{'{6'h20, 16'h2000}, '{6'h10, 16'h1000}, '{6'h08, 16'h0008},
                         '{6'h04, 16'h0004}, '{6'h02, 16'h0002}, '{6'h01, 16'h0001}};
  // aux clock rises in 64 cycles; 125 MHz lies above half the 200 MHz
  // clock, so a registered pin can only show its 75 MHz alias
  int rise_exp [4] = '{8, 16, 24, 0};

  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic        sticky_rst = 1'b0;
  logic        soft_rst = 1'b0;
  logic [4:0]  reg_addr = 5'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [5:0]  evt = 6'h00;
  logic        link_up = 1'b0;
  logic        aneg_master = 1'b0;
  logic        link_partner_swap_adv = 1'b0;
  logic        swap_ack = 1'b0;
  logic [15:0] reg_rdata;
  logic        master_training_enable, swap_advertise, swap_enabled, swap_req, irq;
  logic        aux_clock_output_pin, aux_clock_output_pin_oe;
  int          n_errors = 0;
  int          compares = 0;
  int          n;

  always #2.5 core_clk = ~core_clk;

  per_event_page_regs uut (
    .core_clk, .rst, .sticky_rst, .soft_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .rx_fifo_err(evt[5]), .tx_fifo_err(evt[4]), .eee_link_fail(evt[3]), .eee_rx_quiet(evt[2]),
    .eee_wait_quiet(evt[1]), .eee_wake_err(evt[0]), .link_up, .aneg_master, .link_partner_swap_adv,
    .swap_ack, .master_training_enable, .swap_advertise, .swap_enabled, .swap_req, .irq,
    .aux_clock_output_pin, .aux_clock_output_pin_oe
  );

  // ------------------------------------------------------------
  // bus cycles and comparisons
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [4:0] a, input logic [15:0] exp);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rdata", exp, reg_rdata);
  endtask : rd

  task automatic pulse(input logic [5:0] v);
    @(posedge core_clk);
    evt <= v;
    @(posedge core_clk);
    evt <= 6'h00;
    #1;
  endtask : pulse

  task automatic count_rises(output int cnt);
    logic prev;
    repeat (3) @(posedge core_clk);
    #1;
    cnt  = 0;
    prev = aux_clock_output_pin;
    repeat (64) begin
      @(posedge core_clk);
      #1;
      if (aux_clock_output_pin === 1'b1 && prev === 1'b0) cnt++;
      prev = aux_clock_output_pin;
    end
  endtask : count_rises

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_of_test

  initial begin
    repeat (5000) @(posedge core_clk);
    n_errors++;
    end_of_test();
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    rd(5'h1f, 16'h0000);
    wr(5'h1f, 16'h0002);
    rd(5'h1c, 16'h0000);
    wr(5'h1c, 16'hffff);
    rd(5'h1c, 16'h301f);
    foreach (rows[i]) begin
      pulse(rows[i].ev);
      chk("irq", 16'h0001, {15'h0, irq});
      rd(5'h1d, rows[i].st);
      rd(5'h1d, 16'h0000);
      chk("irq", 16'h0000, {15'h0, irq});
    end
    // masked event stays quiet but is still pending
    wr(5'h1c, 16'h0000);
    pulse(6'h20);
    chk("irq", 16'h0000, {15'h0, irq});
    wr(5'h1f, 16'h0000);
    rd(5'h1d, 16'h0000);
    wr(5'h1f, 16'h0002);
    rd(5'h1d, 16'h2000);
    wr(5'h1c, 16'h301f);
    // timing role swap both ways
    rd(5'h1e, 16'h0000);
    wr(5'h1e, 16'hdffe);
    chk("master_training_enable", 16'h0001, {15'h0, master_training_enable});
    chk("swap_advertise", 16'h0001, {15'h0, swap_advertise});
    chk("swap_enabled", 16'h0001, {15'h0, swap_enabled});
    @(posedge core_clk);
    aneg_master           <= 1'b1;
    link_partner_swap_adv <= 1'b1;
    @(posedge core_clk);
    link_up <= 1'b1;
    repeat (3) @(posedge core_clk);
    rd(5'h1e, 16'hf030);
    wr(5'h1e, 16'hd001);
    chk("swap_req", 16'h0001, {15'h0, swap_req});
    rd(5'h1e, 16'hf011);
    wr(5'h1e, 16'hd001);
    chk("swap_req", 16'h0000, {15'h0, swap_req});
    @(posedge core_clk);
    swap_ack <= 1'b1;
    @(posedge core_clk);
    swap_ack <= 1'b0;
    rd(5'h1e, 16'hf000);
    chk("irq", 16'h0001, {15'h0, irq});
    rd(5'h1d, 16'h0010);
    rd(5'h1d, 16'h0000);
    wr(5'h1e, 16'h1001);
    rd(5'h1e, 16'h3021);
    @(posedge core_clk);
    swap_ack <= 1'b1;
    @(posedge core_clk);
    swap_ack <= 1'b0;
    rd(5'h1e, 16'h3030);
    // soft reset drops pending events and relearns the role from aneg_master, keeps swap controls
    @(posedge core_clk);
    soft_rst <= 1'b1;
    @(posedge core_clk);
    soft_rst <= 1'b0;
    #1;
    chk("irq", 16'h0000, {15'h0, irq});
    rd(5'h1d, 16'h0000);
    rd(5'h1e, 16'h3030);
    // sticky reset clears swap controls but keeps the page
    @(posedge core_clk);
    sticky_rst <= 1'b1;
    @(posedge core_clk);
    sticky_rst <= 1'b0;
    repeat (2) @(posedge core_clk);
    rd(5'h1c, 16'h0000);
    chk("master_training_enable", 16'h0000, {15'h0, master_training_enable});
    chk("swap_enabled", 16'h0000, {15'h0, swap_enabled});
    rd(5'h1f, 16'h0002);
    // aux clock in the general purpose page
    wr(5'h1f, 16'h0010);
    rd(5'h0d, 16'h0000);
    rd(5'h1d, 16'h0000);
    chk("aux_clock_output_pin_oe", 16'h0000, {15'h0, aux_clock_output_pin_oe});
    wr(5'h0d, 16'hffff);
    rd(5'h0d, 16'he000);
    for (int c = 0; c < 4; c++) begin
      wr(5'h0d, 16'h8000 | (16'(c) << 13));
      count_rises(n);
      chk("aux_clock_output_pin_oe", 16'h0001, {15'h0, aux_clock_output_pin_oe});
      compares++;
      if (n < rise_exp[c] - 1 || n > rise_exp[c] + 1) begin
        n_errors++;
        $display("mismatch aux_clock_output_pin rises expected %0d seen %0d", rise_exp[c], n);
      end
    end
    wr(5'h0d, 16'h2000);
    count_rises(n);
    chk("aux_clock_output_pin_oe", 16'h0000, {15'h0, aux_clock_output_pin_oe});
    chk("aux_clock_output_pin rises", 16'h0000, 16'(n));
    @(posedge core_clk);
    sticky_rst <= 1'b1;
    @(posedge core_clk);
    sticky_rst <= 1'b0;
    rd(5'h0d, 16'h2000);
    // power-on reset in mid-run returns the main page
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    rd(5'h1f, 16'h0000);
    end_of_test();
  end
endmodule : per_event_page_regs_test
